// ### rtl/lrcs_regs.v
// Function
// - Bits 31-29 of the retry limit register always read zero and ignore writes.
// - Bits 28-16, the dual-phase cycle limit, always read zero.
// - Bits 15-12 of the retry limit register always read zero.
// - Bits 11-8 hold the physical response unit retry limit, host writable.
// - Bits 7-4 hold the transmit response unit retry limit, host writable.
// - Bits 3-0 hold the transmit request unit retry limit, host writable.
// - The swap data register holds the value stored into the resource on a match.
// - The swap compare register holds the value matched against the resource.
// - The done flag sets when a compare-swap ends and clears on a control write, unless a swap ends in that cycle.
// - A two-bit selector picks bus manager id, bandwidth, channels high or low.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "lrcs_defines.vh"

module lrcs_regs (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [2:0]  unit_new_packet,
    input  wire [2:0]  unit_ack_retry,
    input  wire [2:0]  unit_ack_ok,
    output reg  [2:0]  unit_retransmit,
    output reg  [2:0]  unit_give_up,
    output reg         irq
);

    reg  [11:0] retry_limit_ff;
    reg  [31:0] swap_data_ff;
    reg  [31:0] swap_cmp_ff;
    reg  [1:0]  swap_sel_ff;
    reg         swap_done_ff;
    reg         swap_go_ff;
    reg  [31:0] resource_ff [0:3];
    reg  [3:0]  irq_stat_ff;
    reg  [3:0]  irq_mask_ff;
    reg         wr_pend_ff;
    reg         rd_pend_ff;
    reg  [7:0]  addr_ff;

    wire        access_ok;
    wire        addr_phase_wr;
    wire        addr_phase_rd;
    wire        wr_retry;
    wire        wr_data;
    wire        wr_cmp;
    wire        wr_ctrl;
    wire        wr_stat;
    wire        wr_mask;
    wire [2:0]  nxt_give_up;
    wire [2:0]  nxt_retransmit;
    wire [31:0] swap_old;
    wire [3:0]  irq_events;
    wire [3:0]  nxt_irq_stat;
    reg  [31:0] nxt_hrdata;
    wire [2:0]  dual_phase_second_limit;
    wire [12:0] dual_phase_cycle_limit;
    wire [3:0]  retry_reserved;
    wire [3:0]  phys_response_retry_limit;
    wire [3:0]  tx_response_retry_limit;
    wire [3:0]  tx_request_retry_limit;
    wire [11:0] unit_limits;
    wire [31:0] retry_word;
    wire        compare_swap_done;
    wire [1:0]  compare_swap_resource_select;
    wire [31:0] ctrl_word;
    wire        swap_match;
    wire [2:0]  unit_exhausted;
    wire        swap_finished;
    wire [3:0]  irq_clear;

    assign access_ok     = hsel && hready
                           && (htrans == `LRCS_HTRANS_NONSEQ || htrans == `LRCS_HTRANS_SEQ);
    assign addr_phase_wr = access_ok && hwrite;
    assign addr_phase_rd = access_ok && !hwrite;

    assign wr_retry = wr_pend_ff && (addr_ff == `LRCS_RETRY_OFFSET);
    assign wr_data  = wr_pend_ff && (addr_ff == `LRCS_SWAP_DATA_OFFSET);
    assign wr_cmp   = wr_pend_ff && (addr_ff == `LRCS_SWAP_CMP_OFFSET);
    assign wr_ctrl  = wr_pend_ff && (addr_ff == `LRCS_SWAP_CTRL_OFFSET);
    assign wr_stat  = wr_pend_ff && (addr_ff == `LRCS_IRQ_STAT_OFFSET);
    assign wr_mask  = wr_pend_ff && (addr_ff == `LRCS_IRQ_MASK_OFFSET);

    // Writes complete with no wait state; reads take one wait state so that
    // a read directly behind a write always returns the freshly written value.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0000_0000;
        end
        else
        begin
            hresp <= 1'b0;
            if (rd_pend_ff)
            begin
                rd_pend_ff <= 1'b0;
                hreadyout  <= 1'b1;
                hrdata     <= nxt_hrdata;
            end
            else if (hreadyout)
            begin
                wr_pend_ff <= addr_phase_wr;
                rd_pend_ff <= addr_phase_rd;
                hreadyout  <= !addr_phase_rd;
                if (access_ok)
                begin
                    addr_ff <= {haddr[7:2], 2'b00};
                end
            end
        end
    end

    // Unmapped addresses read as zero and ignore writes
    always @*
    begin
        case (addr_ff)
            `LRCS_RETRY_OFFSET:
                nxt_hrdata = retry_word;
            `LRCS_SWAP_DATA_OFFSET:
                nxt_hrdata = swap_data_ff;
            `LRCS_SWAP_CMP_OFFSET:
                nxt_hrdata = swap_cmp_ff;
            `LRCS_SWAP_CTRL_OFFSET:
                nxt_hrdata = ctrl_word;
            `LRCS_IRQ_STAT_OFFSET:
                nxt_hrdata = {28'h000_0000, irq_stat_ff};
            `LRCS_IRQ_MASK_OFFSET:
                nxt_hrdata = {28'h000_0000, irq_mask_ff};
            default:
                nxt_hrdata = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            retry_limit_ff <= `LRCS_RETRY_RESET;
            irq_mask_ff    <= `LRCS_IRQ_RESET;
        end
        else
        begin
            if (wr_retry)
            begin
                retry_limit_ff <= hwdata[11:0];
            end
            if (wr_mask)
            begin
                irq_mask_ff <= hwdata[3:0];
            end
        end
    end

    // Dual-phase retry is not built, so its two fields and the reserved
    // nibble are constant zero; host writes to them are simply dropped.
    assign dual_phase_second_limit   = 3'h0;
    assign dual_phase_cycle_limit    = 13'h0000;
    assign retry_reserved            = 4'h0;
    assign phys_response_retry_limit = retry_limit_ff[`LRCS_PHYS_RESP_LSB +: 4];
    assign tx_response_retry_limit   = retry_limit_ff[`LRCS_TX_RESP_LSB +: 4];
    assign tx_request_retry_limit    = retry_limit_ff[`LRCS_TX_REQ_LSB +: 4];
    assign unit_limits = {phys_response_retry_limit, tx_response_retry_limit,
                          tx_request_retry_limit};
    assign retry_word  = {dual_phase_second_limit, dual_phase_cycle_limit, retry_reserved,
                          phys_response_retry_limit, tx_response_retry_limit,
                          tx_request_retry_limit};

    assign compare_swap_done            = swap_done_ff;
    assign compare_swap_resource_select = swap_sel_ff;
    assign ctrl_word = {compare_swap_done, 29'h0000_0000, compare_swap_resource_select};

    assign swap_old = resource_ff[swap_sel_ff];
    // The compare sees the operand as it stood before this cycle's writes
    assign swap_match = (swap_old == swap_cmp_ff);

    // A control write latches the selector and launches the swap one cycle
    // later; the swap result overrides a data write landing in that cycle.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            swap_data_ff   <= `LRCS_SWAP_OPND_RESET;
            swap_cmp_ff    <= `LRCS_SWAP_OPND_RESET;
            swap_sel_ff    <= `LRCS_SWAP_SEL_RESET;
            swap_done_ff   <= `LRCS_SWAP_DONE_RESET;
            swap_go_ff     <= 1'b0;
            resource_ff[0] <= `LRCS_BUS_MGR_RESET;
            resource_ff[1] <= `LRCS_BANDWIDTH_RESET;
            resource_ff[2] <= `LRCS_CHAN_HI_RESET;
            resource_ff[3] <= `LRCS_CHAN_LO_RESET;
        end
        else
        begin
            swap_go_ff <= wr_ctrl;
            if (wr_cmp)
            begin
                swap_cmp_ff <= hwdata;
            end
            if (wr_ctrl)
            begin
                swap_sel_ff <= hwdata[1:0];
            end
            if (swap_go_ff)
            begin
                swap_done_ff <= 1'b1;
                swap_data_ff <= swap_old;
                if (swap_match)
                begin
                    resource_ff[swap_sel_ff] <= swap_data_ff;
                end
            end
            else
            begin
                if (wr_ctrl)
                begin
                    swap_done_ff <= 1'b0;
                end
                if (wr_data)
                begin
                    swap_data_ff <= hwdata;
                end
            end
        end
    end

    genvar u;
    generate
        for (u = 0; u < 3; u = u + 1)
        begin : g_unit
            // The compare is not an equality, so a limit lowered in the middle
            // of a packet still ends that packet at its next busy ack.
            reg  [3:0] retry_cnt_ff;
            wire [3:0] limit;
            wire       at_limit;
            assign limit    = unit_limits[4*u +: 4];
            assign at_limit = (retry_cnt_ff >= limit);
            assign nxt_retransmit[u] = unit_ack_retry[u] && !at_limit;
            assign nxt_give_up[u]    = unit_ack_retry[u] && at_limit;

            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    retry_cnt_ff <= 4'h0;
                end
                else if (unit_new_packet[u] || unit_ack_ok[u] || nxt_give_up[u])
                begin
                    retry_cnt_ff <= 4'h0;
                end
                else if (nxt_retransmit[u])
                begin
                    retry_cnt_ff <= retry_cnt_ff + 4'h1;
                end
            end
        end
    endgenerate

    // Set wins over a write-one-to-clear arriving in the same cycle
    assign unit_exhausted = nxt_give_up;
    assign swap_finished  = swap_go_ff;
    assign irq_clear      = wr_stat ? hwdata[3:0] : 4'h0;
    assign irq_events     = {swap_finished, unit_exhausted};
    assign nxt_irq_stat   = (irq_stat_ff & ~irq_clear) | irq_events;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_ff     <= `LRCS_IRQ_RESET;
            irq             <= 1'b0;
            unit_retransmit <= 3'h0;
            unit_give_up    <= 3'h0;
        end
        else
        begin
            irq_stat_ff     <= nxt_irq_stat;
            irq             <= |(nxt_irq_stat & irq_mask_ff);
            unit_retransmit <= nxt_retransmit;
            unit_give_up    <= nxt_give_up;
        end
    end

endmodule // lrcs_regs

`default_nettype wire

// ### shared/lrcs_defines.vh
`ifndef LRCS_DEFINES_VH
`define LRCS_DEFINES_VH

// Register byte offsets
`define LRCS_RETRY_OFFSET     8'h08
`define LRCS_SWAP_DATA_OFFSET 8'h0c
`define LRCS_SWAP_CMP_OFFSET  8'h10
`define LRCS_SWAP_CTRL_OFFSET 8'h14
`define LRCS_IRQ_STAT_OFFSET  8'h20
`define LRCS_IRQ_MASK_OFFSET  8'h24

// Retry limit register fields
`define LRCS_PHYS_RESP_LSB    8
`define LRCS_TX_RESP_LSB      4
`define LRCS_TX_REQ_LSB       0
`define LRCS_RETRY_RW_MASK    32'h0000_0fff
`define LRCS_RETRY_RESET      12'h000

// Compare-swap control fields
`define LRCS_SWAP_DONE_BIT    31
`define LRCS_SWAP_DONE_RESET  1'b1
`define LRCS_SWAP_SEL_RESET   2'h0
`define LRCS_SWAP_OPND_RESET  32'h0000_0000

// Resource selector codes
`define LRCS_SEL_BUS_MGR_ID   2'h0
`define LRCS_SEL_BANDWIDTH    2'h1
`define LRCS_SEL_CHAN_HI      2'h2
`define LRCS_SEL_CHAN_LO      2'h3

// Resource reset values
`define LRCS_BUS_MGR_RESET    32'h0000_003f
`define LRCS_BANDWIDTH_RESET  32'h0000_1333
`define LRCS_CHAN_HI_RESET    32'hffff_ffff
`define LRCS_CHAN_LO_RESET    32'hffff_ffff

// Interrupt status bits: 2..0 retry exhausted per unit, 3 swap done
`define LRCS_IRQ_SWAP_BIT     3
`define LRCS_IRQ_RESET        4'h0

// Bus encodings
`define LRCS_HTRANS_NONSEQ    2'h2
`define LRCS_HTRANS_SEQ       2'h3

`endif

// ### tb/lrcs_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lrcs_regs_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [2:0]  unit_ack_retry,
    input wire logic [2:0]  unit_retransmit,
    input wire logic [2:0]  unit_give_up
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_take;
    assign rd_take = hsel && htrans[1] && hreadyout && !hwrite;
    a_resp_okay: assert property (!hresp) else $error("response not okay");
    a_write_nowait: assert property (hsel && htrans[1] && hreadyout && hwrite |=> hreadyout)
        else $error("write stalled");
    a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    a_stall_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
        else $error("stall without read");
    a_data_stands: assert property ($changed(hrdata) |-> $rose(hreadyout))
        else $error("read data moved");
    a_retry_zero:
        assert property ($rose(hreadyout) && $past(haddr, 2) == 8'h08 |-> hrdata[31:12] == 20'h0_0000)
        else $error("retry upper bits set");
    a_unit_answer:
        assert property ((unit_retransmit | unit_give_up) == $past(unit_ack_retry))
        else $error("busy ack not answered");
    a_unit_excl: assert property ((unit_retransmit & unit_give_up) == 3'h0)
        else $error("retransmit and give up together");
endmodule // lrcs_regs_properties
`default_nettype wire

// ### tb/lrcs_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module lrcs_target_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [2:0] go,
    input  wire logic [3:0] busy_n,
    input  wire logic       slow,
    input  wire logic [2:0] unit_retransmit,
    output logic      [2:0] unit_new_packet,
    output logic      [2:0] unit_ack_retry,
    output logic      [2:0] unit_ack_ok
);
    logic [2:0] pend_ff;
    logic [2:0] wait_ff[3];
    logic [3:0] left_ff[3];
    // Busy budget is per packet; a unit that never gives up gets an ok ack once it runs out
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            pend_ff         <= 3'h0;
            unit_new_packet <= 3'h0;
            unit_ack_retry  <= 3'h0;
            unit_ack_ok     <= 3'h0;
        end
        else
        begin
            unit_new_packet <= go;
            for (int u = 0; u < 3; u++)
            begin
                logic f;
                f = pend_ff[u] && wait_ff[u] == 3'h0;
                unit_ack_retry[u] <= f && left_ff[u] != 4'h0;
                unit_ack_ok[u] <= f && left_ff[u] == 4'h0;
                if (go[u])
                    left_ff[u] <= busy_n;
                else if (f && left_ff[u] != 4'h0)
                    left_ff[u] <= left_ff[u] - 4'h1;
                pend_ff[u] <= go[u] || unit_retransmit[u] || (pend_ff[u] && !f);
                wait_ff[u] <= (go[u] || unit_retransmit[u]) ? {slow, 2'h0}
                            : wait_ff[u] - {2'h0, |wait_ff[u]};
            end
        end
endmodule // lrcs_target_model
`default_nettype wire

// ### tb/lrcs_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lrcs_defines.vh"
module lrcs_regs_tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b1;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd_q;
    logic        hreadyout, hresp, irq;
    logic [2:0]  unit_new_packet, unit_ack_retry, unit_ack_ok, unit_retransmit, unit_give_up;
    logic [2:0]  go = 3'h0;
    logic [3:0]  busy_n = 4'h0;
    logic        slow = 1'b0;
    int          err_total = 0;
    int          check_count = 0;
    int          retx_cnt[3] = '{0, 0, 0};
    int          give_cnt[3] = '{0, 0, 0};
    always #2 hclk = ~hclk;
    lrcs_regs lrcs_regs_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .unit_new_packet, .unit_ack_retry,
        .unit_ack_ok, .unit_retransmit, .unit_give_up, .irq);
    lrcs_target_model lrcs_target_model_i (.hclk, .hresetn, .go, .busy_n, .slow,
        .unit_retransmit, .unit_new_packet, .unit_ack_retry, .unit_ack_ok);
    always @(posedge hclk)
        for (int u = 0; u < 3; u++)
        begin
            retx_cnt[u] <= retx_cnt[u] + unit_retransmit[u];
            give_cnt[u] <= give_cnt[u] + unit_give_up[u];
        end
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_q = hrdata;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        cmp("read data", e, rd_q);
    endtask
    task automatic t_regs;
        rdc(8'h08, 32'h0000_0000);
        rdc(8'h14, 32'h8000_0000);
        rdc(8'h30, 32'h0000_0000);
        ahb(1'b1, 8'h08, 32'hffff_ffff);
        rdc(8'h08, 32'h0000_0fff);
    endtask
    // Limits 0, 2 and 3; the target stays busy one ack past each limit
    task automatic t_units;
        int r0;
        int g0;
        logic [3:0] lim;
        ahb(1'b1, 8'h08, 32'h0000_0320);
        ahb(1'b1, 8'h24, 32'h0000_0006);
        for (int u = 0; u < 3; u++)
        begin
            lim = 4'(32'h320 >> (4 * u));
            r0 = retx_cnt[u];
            g0 = give_cnt[u];
            busy_n <= lim + 4'h1;
            slow <= u[0];
            go <= 3'(1 << u);
            @(posedge hclk);
            go <= 3'h0;
            for (int i = 0; i < 200 && give_cnt[u] == g0; i++) @(posedge hclk);
            @(posedge hclk);
            cmp("retransmits", 32'(lim), 32'(retx_cnt[u] - r0));
            cmp("give ups", 32'h1, 32'(give_cnt[u] - g0));
            cmp("irq masked", 32'(u != 0), {31'h0, irq});
            rdc(8'h20, 32'(1 << u));
            ahb(1'b1, 8'h20, 32'(1 << u));
            rdc(8'h20, 32'h0000_0000);
            cmp("irq cleared", 32'h0, {31'h0, irq});
        end
        // Target accepts the last allowed retry: no give up and no event
        r0 = retx_cnt[1];
        g0 = give_cnt[1];
        busy_n <= 4'h2;
        slow <= 1'b1;
        go <= 3'h2;
        @(posedge hclk);
        go <= 3'h0;
        repeat (40) @(posedge hclk);
        cmp("retransmits", 32'h2, 32'(retx_cnt[1] - r0));
        cmp("give ups", 32'h0, 32'(give_cnt[1] - g0));
        cmp("irq quiet", 32'h0, {31'h0, irq});
    endtask
    task automatic t_swap;
        logic [31:0] rv[4];
        rv = '{`LRCS_BUS_MGR_RESET, `LRCS_BANDWIDTH_RESET, `LRCS_CHAN_HI_RESET, `LRCS_CHAN_LO_RESET};
        ahb(1'b1, 8'h24, 32'h0000_0008);
        for (int s = 0; s < 4; s++)
        begin
            ahb(1'b1, 8'h0c, 32'h1234_0000 + s);
            ahb(1'b1, 8'h10, rv[s]);
            ahb(1'b1, 8'h14, 32'(s));
            repeat (2) @(posedge hclk);
            rdc(8'h0c, rv[s]);
            rdc(8'h14, 32'h8000_0000 + s);
            cmp("irq swap", 32'h1, {31'h0, irq});
            ahb(1'b1, 8'h20, 32'h0000_0008);
            // Compare of zero cannot match the value swapped in above
            ahb(1'b1, 8'h10, 32'h0000_0000);
            ahb(1'b1, 8'h0c, 32'h5555_0000 + s);
            ahb(1'b1, 8'h14, 32'(s));
            repeat (2) @(posedge hclk);
            rdc(8'h0c, 32'h1234_0000 + s);
            // A third swap shows that the failed one left the resource alone
            ahb(1'b1, 8'h14, 32'(s));
            repeat (2) @(posedge hclk);
            rdc(8'h0c, 32'h1234_0000 + s);
            ahb(1'b1, 8'h20, 32'h0000_0008);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_units;
        t_swap;
        stop_test;
    end
    // The run needs about 300 cycles; a hung handshake ends here
    initial
    begin
        #40000;
        err_total++;
        stop_test;
    end
endmodule // lrcs_regs_tb_top
bind lrcs_regs lrcs_regs_properties lrcs_regs_properties_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hrdata, .hreadyout, .hresp, .unit_ack_retry, .unit_retransmit,
    .unit_give_up);
`default_nettype wire
